// File: src/audio_serial_consts.svh
// constants of the audio serial controller: field codes, slot sizes, lanes
// assumes inclusion by its bare name from the package and the design file
`ifndef AUDIO_SERIAL_CONSTS_SVH
`define AUDIO_SERIAL_CONSTS_SVH
`define WORD_W 32
`define DL_32 3'h0
`define DL_24 3'h1
`define DL_20 3'h2
`define DL_18 3'h3
`define DL_16 3'h4
`define DL_16C 3'h5
`define DL_8 3'h6
`define DL_8C 3'h7
`define BITS_32 6'h20
`define BITS_24 6'h18
`define BITS_20 6'h14
`define BITS_18 6'h12
`define BITS_16 6'h10
`define BITS_8 6'h08
`define MCK_MULT 11'h010
`define CH_LEFT 1'b0
`define CH_RIGHT 1'b1
`define RST_WORD 32'h0000_0000
`endif

// File: src/audio_serial_pkg.sv
// types shared by the audio serial controller and its bench
// assumes audio_serial_consts.svh sits on the include path
`include "audio_serial_consts.svh"
package audio_serial_pkg;
  typedef enum logic [1:0] {MODE_SLAVE, MODE_MASTER, MODE_CONTROLLER} mode_t;
  typedef struct packed {
    mode_t mode;
    logic [2:0] sample_length_field;
    logic slot_size_select;
    logic master_clock_output_mode;
    logic [5:0] master_clock_ratio_field;
    logic transmit_mono;
    logic receive_mono;
    logic repeat_last_on_underrun;
  } cfg_t;
  typedef struct packed {
    logic transmitter_disable;
    logic transmitter_enable;
    logic clock_generator_disable;
    logic clock_generator_enable;
    logic receiver_disable;
    logic receiver_enable;
  } ctrl_t;
  typedef struct packed {
    logic [1:0] transmit_underrun_channel_bits;
    logic transmit_underrun_flag;
    logic transmit_ready_flag;
    logic [1:0] receive_overrun_channel_bits;
    logic receive_overrun_flag;
    logic receive_ready_flag;
    logic transmitter_on;
    logic clock_generator_on;
    logic receiver_on;
  } status_t;
endpackage

// File: src/audio_serial_controller.sv
// audio serial controller: clock generator, transmitter, receiver, holding regs
// assumes all inputs synchronous to i_core_clk; config written only when stopped
//
// Overview of operation
// - master/controller drive clocks; controller no data
// - msb first, one bit after word select
// - send on falling, sample on rising
// - word select low left, high right
// - word lengths 8,16,18,20,24,32
// - pad transmit zeros, drop surplus received bits
// - master clock is 32 times (ratio+1) fs
// - bit clock is twice slot times fs
// - output mode: forward clock, divide for bit clock
// - output mode clear: bit clock is core/2, master clock held low
// - mono duplicates left sample to right
// - receive ready set on word, cleared by read
// - unread word: overrun flag and channel bit
// - transmit ready while holding empty, write clears
// - missing word: underrun flag and channel bit
// - underrun sends zero or previous channel word
// - holding samples right-justified, compact packing lanes
// - stop waits for the current frame end
// - holding order is left then right
// - interrupt when flag and its mask set
// - enable ignored when disable written too
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_consts.svh"
module audio_serial_controller import audio_serial_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire cfg_t i_cfg,
  input wire ctrl_t i_ctrl,
  input wire logic i_thr_wr,
  input wire logic [`WORD_W-1:0] i_thr_data,
  input wire logic i_rhr_rd,
  output logic [`WORD_W-1:0] o_rhr_data,
  input wire logic i_clr_overrun,
  input wire logic i_clr_underrun,
  input wire logic [3:0] i_irq_mask,
  output logic o_irq,
  output status_t o_status,
  output logic o_master_clock_pin,
  input wire logic i_bit_clock_pin,
  output logic o_bit_clock_pin,
  output logic o_bit_clock_oe,
  input wire logic i_word_select_pin,
  output logic o_word_select_pin,
  output logic o_word_select_oe,
  input wire logic i_serial_data_in_pin,
  output logic o_serial_data_out_pin
);
  // ----------------------------------------
  // format decode
  // ----------------------------------------
  logic [2:0] dl;
  logic [5:0] slot_bits, word_bits;
  logic cmp, cmp16, drives_clk;
  assign dl = i_cfg.sample_length_field;
  assign cmp = (dl == `DL_16C) || (dl == `DL_8C);
  assign cmp16 = (dl == `DL_16C);
  assign drives_clk = (i_cfg.mode != MODE_SLAVE);
  always_comb begin
    unique case (dl)
      `DL_32: slot_bits = `BITS_32;
      `DL_24, `DL_20, `DL_18: slot_bits = i_cfg.slot_size_select ? `BITS_24 : `BITS_32;
      `DL_16, `DL_16C: slot_bits = `BITS_16;
      `DL_8, `DL_8C: slot_bits = `BITS_8;
    endcase
    unique case (dl)
      `DL_32: word_bits = `BITS_32;
      `DL_24: word_bits = `BITS_24;
      `DL_20: word_bits = `BITS_20;
      `DL_18: word_bits = `BITS_18;
      `DL_16, `DL_16C: word_bits = `BITS_16;
      `DL_8, `DL_8C: word_bits = `BITS_8;
    endcase
  end

  // ----------------------------------------
  // enables: clock generator, receiver, transmitter
  // ----------------------------------------
  logic [2:0] on_q, on_d, pend_q, pend_d, en_v, dis_v;
  logic frame_edge, ck_run, rx_act, tx_act;
  assign en_v = {i_ctrl.transmitter_enable, i_ctrl.clock_generator_enable,
                 i_ctrl.receiver_enable};
  assign dis_v = {i_ctrl.transmitter_disable, i_ctrl.clock_generator_disable,
                  i_ctrl.receiver_disable};
  assign ck_run = drives_clk && on_q[1];
  // controller mode keeps both data paths idle
  assign rx_act = on_q[0] && (i_cfg.mode != MODE_CONTROLLER);
  assign tx_act = on_q[2] && (i_cfg.mode != MODE_CONTROLLER);
  always_comb begin
    on_d = on_q;
    pend_d = pend_q;
    for (int i = 0; i < 3; i++) begin
      // controller mode never starts the data paths, so their status stays low
      if (en_v[i] && !dis_v[i] && (i == 1 || i_cfg.mode != MODE_CONTROLLER)) begin
        on_d[i] = 1'b1;
        pend_d[i] = 1'b0;
      end else if (dis_v[i] && on_q[i]) begin
        pend_d[i] = 1'b1;
      end
      // stop at frame end; in master or controller mode with the clock generator off nothing is in flight
      if (pend_q[i] && !(en_v[i] && !dis_v[i]) &&
          (frame_edge || (drives_clk && !on_q[1]))) begin
        on_d[i] = 1'b0;
        pend_d[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_q <= 3'h0;
      pend_q <= 3'h0;
    end else begin
      on_q <= on_d;
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------
  // clock generator (master and controller)
  // ----------------------------------------
  logic [10:0] half_raw, half, hp_q, hp_d;
  logic [6:0] fcnt_q, fcnt_d;
  logic bck_q, bck_d, ws_q, ws_d, mck_q, mck_d;
  // master clock is core/2, so a bit clock half period is mck/bck core cycles
  assign half_raw = 11'((`MCK_MULT * (11'(i_cfg.master_clock_ratio_field) + 11'h001))
                        / 11'(slot_bits));
  assign half = !i_cfg.master_clock_output_mode ? 11'h001 :
                (half_raw == 11'h000) ? 11'h001 : half_raw;
  always_comb begin
    hp_d = hp_q;
    bck_d = bck_q;
    fcnt_d = fcnt_q;
    ws_d = ws_q;
    mck_d = ck_run && i_cfg.master_clock_output_mode && !mck_q;
    if (!ck_run) begin
      hp_d = 11'h000;
      bck_d = 1'b0;
      fcnt_d = 7'h00;
      ws_d = `CH_LEFT;
    end else if (hp_q == 11'h000) begin
      hp_d = half - 11'h001;
      bck_d = !bck_q;
      if (bck_q) begin
        fcnt_d = (fcnt_q == {slot_bits, 1'b0} - 7'h01) ? 7'h00 : fcnt_q + 7'h01;
        ws_d = (fcnt_d >= 7'(slot_bits)) ? `CH_RIGHT : `CH_LEFT;
      end
    end else begin
      hp_d = hp_q - 11'h001;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hp_q <= 11'h000;
      bck_q <= 1'b0;
      fcnt_q <= 7'h00;
      ws_q <= `CH_LEFT;
      mck_q <= 1'b0;
    end else begin
      hp_q <= hp_d;
      bck_q <= bck_d;
      fcnt_q <= fcnt_d;
      ws_q <= ws_d;
      mck_q <= mck_d;
    end
  end
  assign o_master_clock_pin = mck_q;
  assign o_bit_clock_pin = bck_q;
  assign o_word_select_pin = ws_q;
  assign o_bit_clock_oe = drives_clk;
  assign o_word_select_oe = drives_clk;

  // ----------------------------------------
  // link edges, common to both data paths
  // ----------------------------------------
  logic bck_now, ws_now, bck_prev_q, ws_rise_q, rise, fall, ws_chg;
  assign bck_now = drives_clk ? bck_q : i_bit_clock_pin;
  assign ws_now = drives_clk ? ws_q : i_word_select_pin;
  assign rise = bck_now && !bck_prev_q;
  assign fall = !bck_now && bck_prev_q;
  assign ws_chg = rise && (ws_now != ws_rise_q);
  assign frame_edge = ws_chg && (ws_now == `CH_LEFT);
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bck_prev_q <= 1'b0;
      ws_rise_q <= `CH_LEFT;
    end else begin
      bck_prev_q <= bck_now;
      if (rise) begin
        ws_rise_q <= ws_now;
      end
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [`WORD_W-1:0] hold_q, hold_d, sh_q, sh_d, pend_r_q, pend_r_d, s;
  logic [`WORD_W-1:0] last_q [2], last_d [2];
  logic full_q, full_d, tch_q, tch_d, sdo_q, sdo_d, ur_q, ur_d, take, tsync_q, tsync_d;
  logic [1:0] urch_q, urch_d;
  always_comb begin
    hold_d = i_thr_wr ? i_thr_data : hold_q;
    sh_d = sh_q;
    pend_r_d = pend_r_q;
    last_d = last_q;
    tch_d = tch_q;
    tsync_d = tsync_q && tx_act;
    sdo_d = sdo_q;
    ur_d = ur_q && !i_clr_underrun;
    urch_d = i_clr_underrun ? 2'h0 : urch_q;
    take = 1'b0;
    s = `RST_WORD;
    if (!tx_act) begin
      sdo_d = 1'b0;
    end
    if (fall) begin
      tch_d = ws_rise_q;
      sdo_d = tx_act && sh_q[`WORD_W-1];
      sh_d = {sh_q[`WORD_W-2:0], 1'b0};
      // a new slot is seen one falling edge after word select moved
      if (tx_act && ws_rise_q != tch_q) begin
        // a stream opens on a left slot only, so writes pair left then right
        if (ws_rise_q == `CH_LEFT) begin
          tsync_d = 1'b1;
        end
        if (ws_rise_q == `CH_RIGHT && !tsync_q) begin
          s = `RST_WORD;
        end else if (ws_rise_q == `CH_RIGHT && (cmp || i_cfg.transmit_mono)) begin
          s = pend_r_q;
        end else if (full_q) begin
          take = 1'b1;
          s = !cmp ? hold_q : cmp16 ? {16'h0000, hold_q[15:0]} :
              {24'h00_0000, hold_q[7:0]};
          pend_r_d = i_cfg.transmit_mono ? s : cmp16 ? {16'h0000, hold_q[31:16]} :
                     {24'h00_0000, hold_q[15:8]};
        end else begin
          ur_d = 1'b1;
          urch_d[ws_rise_q] = 1'b1;
          s = i_cfg.repeat_last_on_underrun ? last_q[ws_rise_q] : `RST_WORD;
          pend_r_d = i_cfg.transmit_mono ? s :
                     i_cfg.repeat_last_on_underrun ? last_q[`CH_RIGHT] : `RST_WORD;
        end
        last_d[ws_rise_q] = s;
        sh_d = s << (7'(`BITS_32) - 7'(word_bits));
        sdo_d = sh_d[`WORD_W-1];
        sh_d = {sh_d[`WORD_W-2:0], 1'b0};
      end
    end
    full_d = i_thr_wr || (full_q && !take);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_q <= `RST_WORD;
      sh_q <= `RST_WORD;
      pend_r_q <= `RST_WORD;
      last_q <= '{`RST_WORD, `RST_WORD};
      full_q <= 1'b0;
      tch_q <= `CH_LEFT;
      tsync_q <= 1'b0;
      sdo_q <= 1'b0;
      ur_q <= 1'b0;
      urch_q <= 2'h0;
    end else begin
      hold_q <= hold_d;
      sh_q <= sh_d;
      pend_r_q <= pend_r_d;
      last_q <= last_d;
      full_q <= full_d;
      tch_q <= tch_d;
      tsync_q <= tsync_d;
      sdo_q <= sdo_d;
      ur_q <= ur_d;
      urch_q <= urch_d;
    end
  end
  assign o_serial_data_out_pin = sdo_q;

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [`WORD_W-1:0] rsh_q, rsh_d, rleft_q, rleft_d, rhr_q, rhr_d, r;
  logic [5:0] rcnt_q, rcnt_d;
  logic rsync_q, rsync_d, rdy_q, rdy_d, or_q, or_d, push;
  logic [1:0] orch_q, orch_d;
  always_comb begin
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rleft_d = rleft_q;
    rhr_d = rhr_q;
    rsync_d = rsync_q && rx_act;
    or_d = or_q && !i_clr_overrun;
    orch_d = i_clr_overrun ? 2'h0 : orch_q;
    push = 1'b0;
    r = `RST_WORD;
    if (rise) begin
      if (rcnt_q < word_bits) begin
        rsh_d = {rsh_q[`WORD_W-2:0], i_serial_data_in_pin};
        rcnt_d = rcnt_q + 6'h01;
      end
      if (ws_chg) begin
        if (rx_act && rsync_q) begin
          if (ws_rise_q == `CH_LEFT) begin
            rleft_d = rsh_d;
            push = !cmp;
            r = rsh_d;
          end else begin
            push = 1'b1;
            r = i_cfg.receive_mono ? rleft_q : rsh_d;
            if (cmp) begin
              r = cmp16 ? {r[15:0], rleft_q[15:0]} :
                  {16'h0000, r[7:0], rleft_q[7:0]};
            end
          end
        end
        rsh_d = `RST_WORD;
        rcnt_d = 6'h00;
        // words are delivered from a left slot on, never a lone right first
        rsync_d = rx_act && (rsync_q || ws_now == `CH_LEFT);
      end
    end
    if (push) begin
      rhr_d = r;
      if (rdy_q && !i_rhr_rd) begin
        or_d = 1'b1;
        orch_d[ws_rise_q] = 1'b1;
      end
    end
    rdy_d = push || (rdy_q && !i_rhr_rd);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rsh_q <= `RST_WORD;
      rleft_q <= `RST_WORD;
      rhr_q <= `RST_WORD;
      rcnt_q <= 6'h00;
      rsync_q <= 1'b0;
      rdy_q <= 1'b0;
      or_q <= 1'b0;
      orch_q <= 2'h0;
    end else begin
      rsh_q <= rsh_d;
      rleft_q <= rleft_d;
      rhr_q <= rhr_d;
      rcnt_q <= rcnt_d;
      rsync_q <= rsync_d;
      rdy_q <= rdy_d;
      or_q <= or_d;
      orch_q <= orch_d;
    end
  end
  assign o_rhr_data = rhr_q;

  // ----------------------------------------
  // status and interrupt request
  // ----------------------------------------
  logic [3:0] flags;
  assign flags = {ur_q, !full_q, or_q, rdy_q};
  assign o_irq = |(flags & i_irq_mask);
  assign o_status = '{transmit_underrun_channel_bits: urch_q, transmit_underrun_flag: ur_q,
                      transmit_ready_flag: !full_q, receive_overrun_channel_bits: orch_q,
                      receive_overrun_flag: or_q, receive_ready_flag: rdy_q,
                      transmitter_on: on_q[2], clock_generator_on: on_q[1],
                      receiver_on: on_q[0]};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_rx_ready; push |=> rdy_q; endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("ready not set on word");
  property p_rx_read; i_rhr_rd && !push |=> !rdy_q; endproperty
  a_rx_read: assert property (p_rx_read) else $error("read left ready set");
  property p_overrun; push && rdy_q && !i_rhr_rd |=> or_q && orch_q[$past(ws_rise_q)];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_tx_wr; i_thr_wr |=> !o_status.transmit_ready_flag; endproperty
  a_tx_wr: assert property (p_tx_wr) else $error("ready after write");
  property p_underrun; fall && tx_act && ws_rise_q != tch_q && !full_q &&
    !(ws_rise_q && (cmp || i_cfg.transmit_mono || !tsync_q)) |=> ur_q && urch_q[$past(ws_rise_q)];
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun missed");
  property p_sdo_fall; $changed(sdo_q) && $past(tx_act) |-> $past(fall); endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("data moved off edge");
  property p_ws_fall; ck_run && $past(ck_run) && $changed(ws_q) |-> $past(bck_q) && !bck_q;
  endproperty
  a_ws_fall: assert property (p_ws_fall) else $error("word select off edge");
  property p_ctl_mode; i_cfg.mode == MODE_CONTROLLER |-> !rx_act && !tx_act && o_bit_clock_oe;
  endproperty
  a_ctl_mode: assert property (p_ctl_mode) else $error("controller mode data");
  property p_irq; o_irq == ((o_status.receive_ready_flag && i_irq_mask[0]) ||
    (o_status.receive_overrun_flag && i_irq_mask[1]) ||
    (o_status.transmit_ready_flag && i_irq_mask[2]) ||
    (o_status.transmit_underrun_flag && i_irq_mask[3])); endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_en_dis; !on_q[0] && i_ctrl.receiver_enable && i_ctrl.receiver_disable |=> !on_q[0];
  endproperty
  a_en_dis: assert property (p_en_dis) else $error("enable beat disable");
endmodule
`default_nettype wire

// File: tb/audio_codec_model.sv
// far-side codec model: clock master for slave mode, serial data source and sink
// assumes the bench resolves bit clock and word select from both drivers
`timescale 1ns/1ps
`default_nettype none
module audio_codec_model (
  input wire logic i_gen,
  input wire logic [5:0] i_slot,
  input wire logic [31:0] i_left,
  input wire logic [31:0] i_right,
  input wire logic i_bclk,
  input wire logic i_ws,
  input wire logic i_sdo,
  output logic o_bclk,
  output logic o_ws,
  output logic o_sdi
);
  logic [32:0] got[$];
  logic [31:0] sr = 32'h0;
  logic ws_q = 1'b0;
  int idx = 0;
  int n = 0;
  // ----------------------------------------
  // clocks: bit clock still at 0, word select held, unless generating
  // ----------------------------------------
  initial begin
    o_bclk = 1'b0;
    o_ws = 1'b0;
    o_sdi = 1'b0;
    forever begin
      #20;
      if (i_gen) begin
        o_bclk = 1'b1;
        #20;
        o_bclk = 1'b0;
        n++;
        if (n >= i_slot) begin
          n = 0;
          o_ws = !o_ws;
        end
      end
    end
  end
  // ----------------------------------------
  // data: a word closes where word select moved
  // ----------------------------------------
  always @(posedge i_bclk) begin
    sr = {sr[30:0], i_sdo};
    if (i_ws !== ws_q) begin
      got.push_back({ws_q, sr});
      idx = 0;
    end else begin
      idx++;
    end
    ws_q = i_ws;
  end
  // past 32 bits the line toggles, so stale bits never look valid
  always @(negedge i_bclk) begin
    o_sdi <= #1 (idx > 31) ? !o_sdi : (ws_q ? i_right[31 - idx] : i_left[31 - idx]);
  end
endmodule
`default_nettype wire

// File: tb/audio_serial_controller_tb_top.sv
// bench of the audio serial controller: strobe tasks against a codec model
// assumes the package and constants header on the include path
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_consts.svh"
module audio_serial_controller_tb_top import audio_serial_pkg::*;;
  logic clk, rst_b, thr_wr, rhr_rd, clr_or, clr_ur, irq, peripheral_clock, gen;
  logic bclk_o, bclk_oe, ws_o, ws_oe, sdo, sdi, pm_bclk, pm_ws;
  logic [3:0] mask;
  logic [5:0] slot;
  logic [31:0] thr_data, rhr, pl, pr;
  cfg_t cfg;
  ctrl_t ctrl;
  status_t st;
  int n_fail = 0;
  int compares = 0;
  int nc, nr, nm;
  logic [31:0] txw[4];
  logic [31:0] etx[$];
  logic [31:0] rxq[$];
  int rat[8] = '{3, 2, 3, 2, 1, 1, 0, 0};
  int sl[8] = '{32, 24, 32, 24, 16, 16, 8, 8};
  wire logic bclk_w = bclk_oe ? bclk_o : pm_bclk;
  wire logic ws_w = ws_oe ? ws_o : pm_ws;

  audio_serial_controller dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg),
    .i_ctrl(ctrl), .i_thr_wr(thr_wr), .i_thr_data(thr_data), .i_rhr_rd(rhr_rd),
    .o_rhr_data(rhr), .i_clr_overrun(clr_or), .i_clr_underrun(clr_ur),
    .i_irq_mask(mask), .o_irq(irq), .o_status(st), .o_master_clock_pin(peripheral_clock),
    .i_bit_clock_pin(bclk_w), .o_bit_clock_pin(bclk_o), .o_bit_clock_oe(bclk_oe),
    .i_word_select_pin(ws_w), .o_word_select_pin(ws_o), .o_word_select_oe(ws_oe),
    .i_serial_data_in_pin(sdi), .o_serial_data_out_pin(sdo));
  audio_codec_model pm (.i_gen(gen), .i_slot(slot), .i_left(pl), .i_right(pr),
    .i_bclk(bclk_w), .i_ws(ws_w), .i_sdo(sdo), .o_bclk(pm_bclk), .o_ws(pm_ws),
    .o_sdi(sdi));

  // ----------------------------------------
  // tasks, all entered at a falling edge
  // ----------------------------------------
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic pulse(ctrl_t c);
    ctrl = c;
    @(negedge clk);
    ctrl = 6'h00;
    @(negedge clk);
  endtask
  task automatic clear_flags();
    {clr_or, clr_ur} = 2'h3;
    @(negedge clk);
    {clr_or, clr_ur} = 2'h0;
  endtask
  task automatic write_thr(logic [31:0] d);
    thr_wr = 1'b1;
    thr_data = d;
    @(negedge clk);
    thr_wr = 1'b0;
  endtask
  task automatic read_rhr(output logic [31:0] d);
    d = rhr;
    rhr_rd = 1'b1;
    @(negedge clk);
    rhr_rd = 1'b0;
  endtask
  task automatic setup(mode_t m, logic [2:0] dl, logic ws24, logic [5:0] r);
    cfg = 16'h0000;
    cfg.mode = m;
    cfg.sample_length_field = dl;
    cfg.slot_size_select = ws24;
    cfg.master_clock_output_mode = 1'b1;
    cfg.master_clock_ratio_field = r;
    @(negedge clk);
  endtask
  task automatic stop_all(logic mid);
    pulse(6'h2a);
    if (mid) chk("mid stop", 32'h1, st.clock_generator_on);
    for (int k = 0; k < 3000 && (st.clock_generator_on || st.receiver_on
         || st.transmitter_on); k++) @(negedge clk);
    chk("stopped", 32'h0, {st.transmitter_on, st.clock_generator_on, st.receiver_on});
  endtask
  // one word select period, from rise to rise
  task automatic measure();
    int s;
    logic pw, pb, pmk;
    s = 0;
    {nc, nr, nm} = '0;
    {pw, pb, pmk} = {ws_w, bclk_w, peripheral_clock};
    for (int k = 0; k < 3000 && s < 2; k++) begin
      @(negedge clk);
      if (s == 1) nc++;
      if (s == 1 && bclk_w && !pb) nr++;
      if (s == 1 && peripheral_clock !== pmk) nm++;
      if (ws_w && !pw) s++;
      {pw, pb, pmk} = {ws_w, bclk_w, peripheral_clock};
    end
  endtask
  task automatic run(int nw, logic [31:0] el, logic [31:0] er, logic [31:0] msk);
    logic [31:0] d;
    int j, wi, ri;
    pm.got.delete();
    rxq.delete();
    // a word left over from the previous run would shift the pairing
    if (st.receive_ready_flag === 1'b1) read_rhr(d);
    write_thr(txw[0]);
    pulse(6'h03);
    chk("refused", 32'h0, st.receiver_on);
    pulse(6'h15);
    wi = 1;
    ri = 0;
    for (int k = 0; k < 20000 && (wi < nw || ri < nw); k++) begin
      if (wi < nw && st.transmit_ready_flag === 1'b1) begin
        write_thr(txw[wi]);
        chk("tx taken", 32'h0, st.transmit_ready_flag);
        wi++;
      end else if (ri < nw && st.receive_ready_flag === 1'b1) begin
        chk("irq", {31'h0, mask[0]}, irq);
        read_rhr(d);
        rxq.push_back(d);
        ri++;
      end else @(negedge clk);
    end
    repeat (600) @(negedge clk);
    stop_all(1'b0);
    j = 0;
    foreach (pm.got[i]) begin
      if ((pm.got[i][31:0] & msk) !== 32'h0 && j < etx.size()) begin
        chk("tx data", etx[j], pm.got[i][31:0] & msk);
        chk("tx chan", j % 2, pm.got[i][32]);
        j++;
      end
    end
    chk("tx count", etx.size(), j);
    chk("rx count", nw, rxq.size());
    for (int i = 0; i < rxq.size(); i++)
      chk("rx data", (i % 2 == 0) ? el : er, rxq[i]);
  endtask

  // ----------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end
  initial begin
    #400000;
    n_fail++;
    $display("BAD watchdog exp finish got timeout");
    end_sim();
  end
  initial begin
    {rst_b, thr_wr, rhr_rd, clr_or, clr_ur, gen} = 6'h00;
    {mask, thr_data} = 36'h0;
    cfg = 16'h0000;
    ctrl = 6'h00;
    slot = 6'h10;
    pl = 32'h9abcdef0;
    pr = 32'h13579bdf;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("reset st", 32'h080, {21'h0, st});
    chk("reset rhr", 32'h0, rhr);
    for (int i = 0; i < 8; i++) begin
      setup(MODE_MASTER, i[2:0], i == 1 || i == 3, rat[i][5:0]);
      pulse(6'h15);
      chk("master oe", 32'h3, {bclk_oe, ws_oe});
      measure();
      chk("frame", 64 * (rat[i] + 1), nc);
      chk("bits", 2 * sl[i], nr);
      chk("mck", nc, nm);
      stop_all(1'b1);
    end
    setup(MODE_CONTROLLER, `DL_16, 1'b0, 6'h00);
    cfg.master_clock_output_mode = 1'b0;
    pulse(6'h15);
    chk("ctl on", 32'h2, {st.transmitter_on, st.clock_generator_on, st.receiver_on});
    measure();
    chk("ctl frame", 32'd64, nc);
    chk("ctl mck", 32'h0, nm);
    stop_all(1'b0);
    setup(MODE_MASTER, `DL_24, 1'b0, 6'h07);
    mask = 4'h1;
    txw = '{32'h00abcdef, 32'h00123456, 32'h000f1e2d, 32'h003c4b5a};
    etx = '{32'habcdef00, 32'h12345600, 32'h0f1e2d00, 32'h3c4b5a00};
    run(4, 32'h009abcde, 32'h0013579b, 32'hffffffff);
    mask = 4'hf;
    clear_flags();
    pulse(6'h15);
    repeat (1400) @(negedge clk);
    chk("overrun", 32'h7, {st.receive_overrun_channel_bits, st.receive_overrun_flag});
    chk("underrun", 32'h7, {st.transmit_underrun_channel_bits, st.transmit_underrun_flag});
    chk("irq all", 32'h1, irq);
    chk("zero word", 32'h0, pm.got[$][31:0]);
    clear_flags();
    chk("cleared", 32'h0, {st.transmit_underrun_flag, st.receive_overrun_flag});
    stop_all(1'b0);
    cfg.repeat_last_on_underrun = 1'b1;
    txw[0] = 32'h00777777;
    txw[1] = 32'h00555555;
    etx = '{32'h77777700, 32'h55555500};
    run(2, 32'h009abcde, 32'h0013579b, 32'hffffffff);
    chk("again l", 32'h77777700, pm.got[$-1][31:0]);
    chk("again r", 32'h55555500, pm.got[$][31:0]);
    gen = 1'b1;
    setup(MODE_SLAVE, `DL_16C, 1'b0, 6'h00);
    chk("slave oe", 32'h0, {bclk_oe, ws_oe});
    txw[0] = 32'hbeefcafe;
    txw[1] = 32'h12345678;
    etx = '{32'hcafe, 32'hbeef, 32'h5678, 32'h1234};
    run(2, 32'h13579abc, 32'h13579abc, 32'h0000ffff);
    cfg.sample_length_field = `DL_16;
    cfg.transmit_mono = 1'b1;
    cfg.receive_mono = 1'b1;
    txw[0] = 32'h0000a1b2;
    txw[1] = 32'h0000c3d4;
    etx = '{32'ha1b2, 32'ha1b2, 32'hc3d4, 32'hc3d4};
    run(2, 32'h00009abc, 32'h00009abc, 32'h0000ffff);
    gen = 1'b0;
    end_sim();
  end
endmodule
`default_nettype wire
